// ==== rtl/scr_core.sv ====
`timescale 1ns/1ps
module scrt_core
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [scrt_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dma_rx_rd,
  input wire logic dma_tx_wr,
  input wire logic [7:0] dma_tx_data,
  output logic [7:0] rx_data_out,
  output logic rx_full_irq,
  output logic tx_empty_irq,
  output logic comm_error_irq,
  output logic irq
);
  import scrt_pkg::*;

  logic [1:0] sync_q;
  logic [1:0] rise;
  logic [1:0] fall;
  logic data_s;
  logic tick;
  logic data_fall;

  // link clock is just sampled; its rising edges are the base clock pulses
  scrt_sync #(.W(2)) u_sync
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .d({link_clk, data_in}),
    .q(sync_q)
  );
  scrt_edge #(.W(2)) u_edge
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .sig(sync_q),
    .rise(rise),
    .fall(fall)
  );
  assign data_s = sync_q[0];
  // R1: one pulse per base clock
  assign tick = rise[1];
  assign data_fall = fall[0];

  scrt_state_t st_reg, st_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [8:0] sh_reg, sh_next;
  logic [7:0] hold_reg, hold_next;
  logic oe_n_reg, oe_n_next;
  logic err_reg, err_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [4:0] stat_reg, stat_next;
  logic [4:0] mask_reg, mask_next;
  logic [7:0] txd_reg, txd_next;
  logic [7:0] rxd_reg, rxd_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic rfi_reg, rfi_next;
  logic tei_reg, tei_next;
  logic cei_reg, cei_next;
  logic irq_reg, irq_next;
  logic ev_rx_ok, ev_par_err, ev_err_sig, ev_tx_done;
  logic etu_end, mid;
  logic [8:0] frame;
  logic [9:0] tx_bits;

  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    hold_next = hold_reg;
    oe_n_next = oe_n_reg;
    err_next = err_reg;
    ev_rx_ok = 1'b0;
    ev_par_err = 1'b0;
    ev_err_sig = 1'b0;
    ev_tx_done = 1'b0;
    frame = {data_s, sh_reg[8:1]};
    tx_bits = {^hold_reg, hold_reg, 1'b0};
    etu_end = tick && (cnt_reg == ETU_END);
    // R3: capture on the 186th pulse of each bit period
    mid = tick && (cnt_reg == SAMPLE_CNT);
    if (tick)
      cnt_next = etu_end ? 9'h000 : cnt_reg + 9'h001;
    if (etu_end)
      bit_next = bit_reg + 4'h1;
    unique case (st_reg)
      SCRT_IDLE:
      begin
        cnt_next = 9'h000;
        bit_next = 4'h0;
        err_next = 1'b0;
        oe_n_next = 1'b1;
        // transmit wins when both directions are enabled
        if (ctrl_reg[CTRL_TX_EN] && !stat_reg[ST_TX_EMPTY])
        begin
          st_next = SCRT_TX;
          hold_next = txd_reg;
          oe_n_next = 1'b0;
        end
        // R2: start-bit fall aligns timing
        else if (ctrl_reg[CTRL_RX_EN] && data_fall)
          st_next = SCRT_RX;
      end
      SCRT_RX:
      begin
        if (mid && bit_reg == 4'h0 && data_s)
          st_next = SCRT_IDLE;
        else if (mid && bit_reg != 4'h0 && bit_reg <= BIT_PARITY)
        begin
          sh_next = frame;
          // R5: even parity over data and parity bit
          if (bit_reg == BIT_PARITY && ^frame)
          begin
            ev_par_err = 1'b1;
            err_next = 1'b1;
          end
          // R8: clean frame
          else if (bit_reg == BIT_PARITY)
            ev_rx_ok = 1'b1;
        end
        // R18: pull low from mid error slot to mid guard bit
        if (mid && bit_reg == BIT_ERRSIG && err_reg)
          oe_n_next = 1'b0;
        // R10: released mid guard bit on every frame; a clean frame never pulls low
        if (mid && bit_reg == BIT_GUARD)
          oe_n_next = 1'b1;
        // R4: ten bits plus error slot and guard
        if (etu_end && bit_reg == BIT_GUARD)
          st_next = SCRT_IDLE;
      end
      SCRT_TX:
      begin
        if (etu_end)
          oe_n_next = (bit_next < FRAME_BITS) ? tx_bits[bit_next] : 1'b1;
        // R19: low in the error slot is an error
        if (etu_end && bit_reg == BIT_ERRSIG && !data_s)
        begin
          // R11: flag and error irq
          err_next = 1'b1;
          ev_err_sig = 1'b1;
        end
        if (etu_end && bit_reg == BIT_GUARD)
        begin
          // R16: resend the held character
          // R13: no end after error
          if (err_reg)
          begin
            bit_next = 4'h0;
            err_next = 1'b0;
            oe_n_next = 1'b0;
          end
          else
          begin
            ev_tx_done = 1'b1;
            st_next = SCRT_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= SCRT_IDLE;
      cnt_reg <= 9'h000;
      bit_reg <= 4'h0;
      sh_reg <= 9'h000;
      hold_reg <= 8'h00;
      oe_n_reg <= 1'b1;
      err_reg <= 1'b0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      hold_reg <= hold_next;
      oe_n_reg <= oe_n_next;
      err_reg <= err_next;
    end
  end

  logic req, wr, txd_wr;
  logic [4:0] set_v, clr_v;

  always_comb
  begin
    req = wb_cyc_i && wb_stb_i;
    // write lands on the edge that the master sees ack
    wr = req && ack_reg && wb_we_i && wb_sel_i[0];
    txd_wr = dma_tx_wr || (wr && wb_adr_i == ADR_TXD);
    ack_next = req && !ack_reg;
    rdat_next = 32'h0000_0000;
    if (req && !ack_reg && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ADR_CTRL: rdat_next = {28'h0000000, ctrl_reg};
        ADR_STAT: rdat_next = {27'h0000000, stat_reg};
        ADR_MASK: rdat_next = {27'h0000000, mask_reg};
        ADR_TXD: rdat_next = {24'h000000, txd_reg};
        ADR_RXD: rdat_next = {24'h000000, rxd_reg};
        default: rdat_next = 32'h0000_0000;
      endcase
    end
    ctrl_next = (wr && wb_adr_i == ADR_CTRL) ? wb_dat_i[3:0] : ctrl_reg;
    mask_next = (wr && wb_adr_i == ADR_MASK) ? wb_dat_i[4:0] : mask_reg;
    txd_next = dma_tx_wr ? dma_tx_data : (txd_wr ? wb_dat_i[7:0] : txd_reg);
    // R7: erroneous byte still readable, full flag untouched
    rxd_next = (ev_rx_ok || ev_par_err) ? frame[7:0] : rxd_reg;
    // R17: empty and end rise together
    set_v = {ev_tx_done, ev_tx_done, ev_err_sig, ev_par_err, ev_rx_ok};
    clr_v = (wr && wb_adr_i == ADR_STAT) ? (wb_dat_i[4:0] & STAT_W1C) : 5'h00;
    // R9: dma read empties receive data
    if (dma_rx_rd)
      clr_v[ST_RX_FULL] = 1'b1;
    // R15: new transmit data clears empty and end
    if (txd_wr)
      clr_v = clr_v | 5'h18;
    // set beats a clear in the same cycle
    stat_next = (stat_reg & ~clr_v) | set_v;
    rfi_next = stat_next[ST_RX_FULL] && ctrl_next[CTRL_RX_IRQ_EN];
    cei_next = (stat_next[ST_PAR_ERR] || stat_next[ST_ERR_SIG]) && ctrl_next[CTRL_RX_IRQ_EN];
    // R14: transmit irq from transmit-end
    tei_next = stat_next[ST_TX_END] && ctrl_next[CTRL_TX_IRQ_EN];
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg <= CTRL_RST;
      stat_reg <= STAT_RST;
      mask_reg <= MASK_RST;
      txd_reg <= 8'h00;
      rxd_reg <= 8'h00;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      rfi_reg <= 1'b0;
      tei_reg <= 1'b0;
      cei_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      txd_reg <= txd_next;
      rxd_reg <= rxd_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      rfi_reg <= rfi_next;
      tei_reg <= tei_next;
      cei_reg <= cei_next;
      irq_reg <= irq_next;
    end
  end

  // open-drain: only ever drives low
  assign data_out = 1'b0;
  assign data_oe_n = oe_n_reg;
  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign rx_data_out = rxd_reg;
  assign rx_full_irq = rfi_reg;
  assign tx_empty_irq = tei_reg;
  assign comm_error_irq = cei_reg;
  assign irq = irq_reg;

  // ticks since alignment, only watched by checks
  logic [12:0] since_reg;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      since_reg <= 13'h0000;
    else if (ce && st_reg == SCRT_IDLE)
      since_reg <= 13'h0000;
    else if (ce && tick)
      since_reg <= since_reg + 13'h0001;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn || !ce);

  property p_par_time;
    (ev_rx_ok || ev_par_err) |-> since_reg == PARITY_TICKS - 13'h0001;
  endproperty
  a_par_time: assert property (p_par_time) else $error("parity sample off 186th pulse"); // R3
  property p_align;
    (st_reg == SCRT_IDLE && ctrl_reg[CTRL_RX_EN] && !ctrl_reg[CTRL_TX_EN] && data_fall)
      |=> st_reg == SCRT_RX && cnt_reg == 9'h000 && bit_reg == 4'h0;
  endproperty
  a_align: assert property (p_align) else $error("no alignment on start fall"); // R2
  property p_par_flag;
    ev_par_err |=> stat_reg[ST_PAR_ERR] && !$rose(stat_reg[ST_RX_FULL]);
  endproperty
  a_par_flag: assert property (p_par_flag) else $error("parity error handling wrong"); // R5
  property p_rx_ok;
    ev_rx_ok |=> stat_reg[ST_RX_FULL] && $stable(stat_reg[ST_PAR_ERR]);
  endproperty
  a_rx_ok: assert property (p_rx_ok) else $error("good frame not flagged full"); // R8
  property p_dma_rd;
    dma_rx_rd && !ev_rx_ok |=> !stat_reg[ST_RX_FULL];
  endproperty
  a_dma_rd: assert property (p_dma_rd) else $error("dma read left full set"); // R9
  property p_quiet;
    (st_reg == SCRT_RX && !err_reg) |-> oe_n_reg;
  endproperty
  a_quiet: assert property (p_quiet) else $error("line driven on good frame"); // R10
  property p_err_drive;
    (st_reg == SCRT_RX && bit_reg == BIT_GUARD && cnt_reg < SAMPLE_CNT) |-> oe_n_reg == !err_reg;
  endproperty
  a_err_drive: assert property (p_err_drive) else $error("error slot drive wrong"); // R18
  property p_ers;
    ev_err_sig |-> !ev_tx_done ##1 stat_reg[ST_ERR_SIG];
  endproperty
  a_ers: assert property (p_ers) else $error("error signal flag wrong"); // R11
  property p_resend;
    (st_reg == SCRT_TX && err_reg && etu_end && bit_reg == BIT_GUARD)
      |=> st_reg == SCRT_TX && bit_reg == 4'h0 && !oe_n_reg && $stable(hold_reg);
  endproperty
  a_resend: assert property (p_resend) else $error("no resend after error"); // R16
  property p_tx_end;
    $rose(stat_reg[ST_TX_END]) |-> stat_reg[ST_TX_EMPTY] && $past(ev_tx_done);
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit end without empty"); // R17
  property p_dma_wr;
    dma_tx_wr && !ev_tx_done |=> !stat_reg[ST_TX_EMPTY] && txd_reg == $past(dma_tx_data);
  endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("dma write left empty set"); // R15
  property p_irq;
    irq == |(stat_reg & mask_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  c_rx_ok: cover property (ev_rx_ok);
  c_rx_bad: cover property (st_reg == SCRT_RX && !oe_n_reg);
  c_resend: cover property (ev_err_sig);
  c_tx_done: cover property (ev_tx_done);
endmodule

// ==== rtl/scr_edge.sv ====
`timescale 1ns/1ps
module scrt_edge #(parameter int W = 1)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] sig,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_reg;
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign rise[i] = sig[i] & ~prev_reg[i];
    assign fall[i] = ~sig[i] & prev_reg[i];
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
        prev_reg[i] <= 1'b0;
      else if (ce)
        prev_reg[i] <= sig[i];
    end
  end
endmodule

// ==== rtl/scr_pkg.sv ====
// What this block does
// R1: base clock runs at 372x bit rate
// R2: align bit timing to start-bit fall
// R3: capture each bit on 186th base pulse
// R4: frame is ten bit periods long
// R5: parity mismatch sets parity error, error irq
// R6: software clears parity error before next parity
// R7: bad-parity frame leaves receive-full untouched
// R8: good parity sets receive-full and its irq
// R9: dma read of receive data clears receive-full
// R10: good frame leaves line released in error slot
// R11: returned error signal sets error-signal flag, irq
// R12: software clears error-signal flag before next parity
// R13: no transmit-end for an errored frame
// R14: clean frame sets transmit-end and transmit irq
// R15: dma write of transmit data clears empty
// R16: error signal resends same character automatically
// R17: transmit-empty set together with transmit-end
// R18: receive parity error drives line low
// R19: transmit samples error slot, low means error
package scrt_pkg;
  localparam int BASE_RATIO = 372;
  localparam int SAMPLE_PULSE = 186;
  localparam logic [8:0] ETU_END = 9'(BASE_RATIO - 1);
  localparam logic [8:0] SAMPLE_CNT = 9'(SAMPLE_PULSE - 1);
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] BIT_PARITY = 4'h9;
  localparam logic [3:0] BIT_ERRSIG = 4'hA;
  localparam logic [3:0] BIT_GUARD = 4'hB;
  localparam logic [12:0] PARITY_TICKS = 13'(9 * BASE_RATIO + SAMPLE_PULSE);
  localparam int ADR_W = 5;
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_STAT = 5'h04;
  localparam logic [4:0] ADR_MASK = 5'h08;
  localparam logic [4:0] ADR_TXD = 5'h0C;
  localparam logic [4:0] ADR_RXD = 5'h10;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_TX_IRQ_EN = 2;
  localparam int CTRL_RX_IRQ_EN = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int ST_RX_FULL = 0;
  localparam int ST_PAR_ERR = 1;
  localparam int ST_ERR_SIG = 2;
  localparam int ST_TX_END = 3;
  localparam int ST_TX_EMPTY = 4;
  localparam logic [4:0] STAT_RST = 5'h18;
  localparam logic [4:0] STAT_W1C = 5'h0F;
  localparam logic [4:0] MASK_RST = 5'h00;
  typedef enum logic [1:0] {SCRT_IDLE, SCRT_RX, SCRT_TX} scrt_state_t;
endpackage

// ==== rtl/scr_sync.sv ====
`timescale 1ns/1ps
module scrt_sync #(parameter int W = 1)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  assign q = q_reg;
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        meta_reg[i] <= 1'b0;
        q_reg[i] <= 1'b0;
      end
      else if (ce)
      begin
        meta_reg[i] <= d[i];
        q_reg[i] <= meta_reg[i];
      end
    end
  end
endmodule

// ==== verif/scr_card_model.sv ====
`timescale 1ns/1ps
module scrt_card_model
(
  input wire logic link_clk,
  input wire logic line,
  output logic card_lvl
);
  initial card_lvl = 1'b1;

  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {(^d) ^ bad, d, 1'b0};
    @(posedge link_clk);
    for (int k = 0; k < 10; k++)
    begin
      card_lvl <= f[k];
      repeat (372) @(posedge link_clk);
    end
    // line released through the error slot, then guard time
    card_lvl <= 1'b1;
    repeat (744) @(posedge link_clk);
  endtask

  // ten-bit frame in, optional low reply
  task automatic recv(input logic nak, output logic [9:0] f);
    @(negedge line);
    repeat (186) @(posedge link_clk);
    for (int k = 0; k < 10; k++)
    begin
      f[k] = line;
      repeat (372) @(posedge link_clk);
    end
    if (nak)
      card_lvl <= 1'b0;
    repeat (372) @(posedge link_clk);
    card_lvl <= 1'b1;
  endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import scrt_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic link_clk = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [4:0] wb_adr = 5'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic dma_rx_rd = 1'b0;
  logic dma_tx_wr = 1'b0;
  logic [7:0] dma_tx_data = 8'h00;
  logic data_out, data_oe_n, wb_ack_o, rx_full_irq, tx_empty_irq, comm_error_irq, irq;
  logic card_lvl, line;
  logic [31:0] wb_dat_o, rd;
  logic [7:0] rx_data_out, d;
  logic [9:0] f1, f2;
  int err_total = 0;
  int comparisons = 0;
  int low_cnt = 0;

  // open-drain line with pull-up
  assign line = card_lvl & (data_oe_n | data_out);

  always #2 clk_sys = ~clk_sys;
  initial
  begin
    #13.7;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge clk_sys)
    if (data_oe_n === 1'b0)
      low_cnt++;

  scrt_core dut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .link_clk(link_clk),
    .data_in(line), .data_out(data_out), .data_oe_n(data_oe_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_rx_rd(dma_rx_rd),
    .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data), .rx_data_out(rx_data_out),
    .rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq),
    .comm_error_irq(comm_error_irq), .irq(irq));
  scrt_card_model card (.link_clk(link_clk), .line(line), .card_lvl(card_lvl));

  function automatic logic [9:0] frame_of(input logic [7:0] v);
    return {^v, v, 1'b0};
  endfunction

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= wd;
    // only the watchdog ends a wait for ack
    do
    begin
      @(posedge clk_sys);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task finish_test;
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bound: four frames of 12 bit times plus margin
  initial
  begin
    #5000000;
    err_total++;
    finish_test;
  end

  initial
  begin
    void'($urandom(62));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    bus(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, 32'h18);
    bus(1'b0, ADR_CTRL, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, 5'h14, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, ADR_CTRL, 32'h0A, rd);
    bus(1'b1, ADR_MASK, 32'h03, rd);
    bus(1'b0, ADR_MASK, 32'h0, rd);
    check(rd, 32'h03);
    d = 8'($urandom);
    low_cnt = 0;
    card.send(d, 1'b0);
    check({24'h0, rx_data_out}, {24'h0, d});
    check(32'(low_cnt), 32'h0);
    check({30'h0, irq, rx_full_irq}, 32'h3);
    bus(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, 32'h19);
    bus(1'b1, ADR_MASK, 32'h00, rd);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    dma_rx_rd <= 1'b1;
    @(posedge clk_sys);
    dma_rx_rd <= 1'b0;
    bus(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, 32'h18);
    bus(1'b1, ADR_MASK, 32'h02, rd);
    d = 8'($urandom);
    low_cnt = 0;
    card.send(d, 1'b1);
    bus(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, 32'h1A);
    check({30'h0, irq, comm_error_irq}, 32'h3);
    check(32'((low_cnt + 10) / 20), 32'd372);
    check({31'h0, data_out}, 32'h0);
    check({24'h0, rx_data_out}, {24'h0, d});
    bus(1'b0, ADR_RXD, 32'h0, rd);
    check(rd, {24'h0, d});
    bus(1'b1, ADR_STAT, 32'h02, rd);
    bus(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, 32'h18);
    bus(1'b1, ADR_CTRL, 32'h0D, rd);
    d = 8'($urandom);
    fork
      begin
        card.recv(1'b1, f1);
        bus(1'b0, ADR_STAT, 32'h0, rd);
        check(rd, 32'h04);
        bus(1'b1, ADR_STAT, 32'h04, rd);
        card.recv(1'b0, f2);
      end
      begin
        @(posedge clk_sys);
        dma_tx_wr <= 1'b1;
        dma_tx_data <= d;
        @(posedge clk_sys);
        dma_tx_wr <= 1'b0;
        bus(1'b0, ADR_STAT, 32'h0, rd);
        check(rd, 32'h00);
        bus(1'b0, ADR_TXD, 32'h0, rd);
        check(rd, {24'h0, d});
      end
    join
    check({22'h0, f1}, {22'h0, frame_of(d)});
    check({22'h0, f2}, {22'h0, frame_of(d)});
    repeat (400) @(posedge link_clk);
    bus(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, 32'h18);
    check({31'h0, tx_empty_irq}, 32'h1);
    finish_test;
  end
endmodule
